// ===== logic/rtcw_core.sv
// Always-on BCD calendar with alarms, periodic events and wake control.
`timescale 1ns/1ns
`include "rtcw_consts.svh"
module rtcw_core (
  // Clock and clock-supply power-on reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_sys_rst,
  // Crystal and core power
  input  wire logic        i_xtal_clk,
  input  wire logic        i_core_pgood,
  // Memory-mapped register port
  input  wire logic [15:0] i_reg_addr,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [15:0] i_reg_wdata,
  output logic      [15:0] o_reg_rdata,
  output logic             o_reg_ready,
  // Wake pin and system control
  input  wire logic        i_wake_in,
  output logic             o_wake_out,
  output logic             o_wake_oe,
  output logic             o_irq,
  output logic             o_core_reg_off,
  output logic             o_isolate,
  output logic             o_sys_reset
);

  logic             xs1_ff, xs2_ff, xs3_ff;
  logic             ws1_ff, ws2_ff, wake_t_ff;
  logic             tick;
  rtcw_pkg::rtcw_sync_t st_ff;
  logic      [15:0] pa_ff, pd_ff;
  logic             wr_acc, osc_wr, apply, pend_time;
  logic      [15:0] ie_ff, upd_ff, flags_ff, nopwr_ff, per_ff, drift_ff;
  logic      [15:0] osc_ff, pwr_ff;
  logic      [15:0] scr_ff [4];
  logic      [11:0] ms_ff, ms_alm_ff, nxt_ms;
  logic       [7:0] sec_ff, min_ff, hour_ff, date_ff, mon_ff, year_ff;
  logic       [7:0] nxt_sec, nxt_min, nxt_hour, nxt_date, nxt_mon, nxt_year;
  logic       [2:0] wday_ff, nxt_wday;
  logic      [15:0] sec_alm_ff, min_alm_ff, hour_alm_ff, day_alm_ff;
  logic      [15:0] mon_alm_ff, year_alm_ff;
  logic      [16:0] acc_ff, acc_sum, acc_thr;
  logic             ms_step, step_ok, c_sec, c_min, c_hour, c_day, c_mon;
  logic             alarm_hit, per_hit, wake_hit;
  logic             iso_ff, pgood_d_ff;
  logic      [15:0] rdata_ff;

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction : bcd_inc

  // Years 00..99 stand for 2000..2099, so every year divisible by 4 leaps.
  function automatic logic is_leap(input logic [7:0] y);
    is_leap = (!y[4] && (y[3:0] == 4'h0 || y[3:0] == 4'h4 ||
                         y[3:0] == 4'h8)) ||
              (y[4] && (y[3:0] == 4'h2 || y[3:0] == 4'h6));
  endfunction : is_leap

  function automatic logic [7:0] last_day(input logic [7:0] m,
                                          input logic [7:0] y);
    case (m)
      8'h02:                      last_day = is_leap(y) ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: last_day = 8'h30;
      default:                    last_day = 8'h31;
    endcase
  endfunction : last_day

  // The crystal is sampled as a level; the second and third stages form the rising-edge tick.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      xs1_ff <= 1'b0;
      xs2_ff <= 1'b0;
      xs3_ff <= 1'b0;
    end else begin
      xs1_ff <= i_xtal_clk;
      xs2_ff <= xs1_ff;
      xs3_ff <= xs2_ff;
    end
  end

  // A stopped oscillator gives no ticks, so time and pending writes freeze.
  assign tick = xs2_ff && !xs3_ff && osc_ff[`RTCW_OSC_EN_BIT];

  // Isolation follows power-good; its rise asks for a system reset.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      iso_ff     <= 1'b1;
      pgood_d_ff <= 1'b0;
    end else begin
      iso_ff     <= !i_core_pgood;
      pgood_d_ff <= i_core_pgood;
    end
  end

  assign o_isolate   = iso_ff;
  assign o_sys_reset = i_core_pgood && !pgood_d_ff;

  // Write synchroniser: a write waits for two crystal ticks. The
  // oscillator register bypasses it, else a stopped crystal locks it out.
  assign o_reg_ready = (st_ff == rtcw_pkg::rtcw_st_idle) && !iso_ff;
  assign osc_wr = i_reg_wr && o_reg_ready && i_reg_addr == `RTCW_OFS_OSC;
  assign wr_acc = i_reg_wr && o_reg_ready && !osc_wr &&
                  osc_ff[`RTCW_OSC_EN_BIT];
  assign apply  = (st_ff == rtcw_pkg::rtcw_st_tick2) && tick;

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      st_ff <= rtcw_pkg::rtcw_st_idle;
      pa_ff <= 16'h0000;
      pd_ff <= 16'h0000;
    end else begin
      case (st_ff)
        rtcw_pkg::rtcw_st_idle: begin
          if (wr_acc) begin
            st_ff <= rtcw_pkg::rtcw_st_tick1;
            pa_ff <= i_reg_addr;
            pd_ff <= i_reg_wdata;
          end
        end
        rtcw_pkg::rtcw_st_tick1: begin
          if (tick) begin
            st_ff <= rtcw_pkg::rtcw_st_tick2;
          end
        end
        rtcw_pkg::rtcw_st_tick2: begin
          if (tick) begin
            st_ff <= rtcw_pkg::rtcw_st_idle;
          end
        end
        default: st_ff <= rtcw_pkg::rtcw_st_idle;
      endcase
    end
  end

  // Millisecond divider: 1000 counts per 32768 ticks plus signed drift.
  always_comb begin
    acc_thr = `RTCW_MS_ACC_BASE + {drift_ff[15], drift_ff};
    acc_sum = acc_ff + `RTCW_MS_ACC_STEP;
    ms_step = tick && (acc_sum >= acc_thr);
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      acc_ff <= 17'h00000;
    end else if (tick) begin
      acc_ff <= ms_step ? acc_sum - acc_thr : acc_sum;
    end
  end

  // A write to a time field holds the whole count for that tick.
  assign pend_time = pa_ff == `RTCW_OFS_MS  || pa_ff == `RTCW_OFS_SEC ||
                     pa_ff == `RTCW_OFS_MIN || pa_ff == `RTCW_OFS_HOUR ||
                     pa_ff == `RTCW_OFS_DAY || pa_ff == `RTCW_OFS_MONTH ||
                     pa_ff == `RTCW_OFS_YEAR;
  assign step_ok = ms_step && !upd_ff[`RTCW_UPD_FREEZE_BIT] &&
                   !(apply && pend_time);

  always_comb begin
    c_sec  = step_ok && ms_ff == 12'h999;
    c_min  = c_sec && sec_ff == 8'h59;
    c_hour = c_min && min_ff == 8'h59;
    c_day  = c_hour && hour_ff == 8'h23;
    c_mon  = c_day && date_ff == last_day(mon_ff, year_ff);
    nxt_ms = (ms_ff[7:0] == 8'h99) ? {ms_ff[11:8] + 4'h1, 8'h00}
                                   : {ms_ff[11:8], bcd_inc(ms_ff[7:0])};
    nxt_ms   = c_sec ? 12'h000 : nxt_ms;
    nxt_sec  = (sec_ff == 8'h59) ? 8'h00 : bcd_inc(sec_ff);
    nxt_min  = (min_ff == 8'h59) ? 8'h00 : bcd_inc(min_ff);
    nxt_hour = (hour_ff == 8'h23) ? 8'h00 : bcd_inc(hour_ff);
    nxt_wday = (wday_ff == 3'h7) ? 3'h1 : wday_ff + 3'h1;
    nxt_date = c_mon ? `RTCW_BCD_ONE : bcd_inc(date_ff);
    nxt_mon  = (mon_ff == 8'h12) ? `RTCW_BCD_ONE : bcd_inc(mon_ff);
    nxt_year = (year_ff == 8'h99) ? 8'h00 : bcd_inc(year_ff);
  end

  // Calendar counters: a pending write loads, otherwise the count steps.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      ms_ff   <= 12'h000;
      sec_ff  <= 8'h00;
      min_ff  <= 8'h00;
      hour_ff <= 8'h00;
      date_ff <= `RTCW_BCD_ONE;
      wday_ff <= 3'h1;
      mon_ff  <= `RTCW_BCD_ONE;
      year_ff <= 8'h00;
    end else if (apply && pend_time) begin
      if (pa_ff == `RTCW_OFS_MS)    ms_ff   <= pd_ff[11:0];
      if (pa_ff == `RTCW_OFS_SEC)   sec_ff  <= pd_ff[7:0];
      if (pa_ff == `RTCW_OFS_MIN)   min_ff  <= pd_ff[7:0];
      if (pa_ff == `RTCW_OFS_HOUR)  hour_ff <= pd_ff[7:0];
      if (pa_ff == `RTCW_OFS_DAY) begin
        date_ff <= pd_ff[7:0];
        wday_ff <= pd_ff[10:8];
      end
      if (pa_ff == `RTCW_OFS_MONTH) mon_ff  <= pd_ff[7:0];
      if (pa_ff == `RTCW_OFS_YEAR)  year_ff <= pd_ff[7:0];
    end else if (step_ok) begin
      ms_ff <= nxt_ms;
      if (c_sec)  sec_ff  <= nxt_sec;
      if (c_min)  min_ff  <= nxt_min;
      if (c_hour) hour_ff <= nxt_hour;
      if (c_day) begin
        date_ff <= nxt_date;
        wday_ff <= nxt_wday;
      end
      if (c_mon)  mon_ff  <= nxt_mon;
      if (c_mon && mon_ff == 8'h12) year_ff <= nxt_year;
    end
  end

  // Alarm levels compare ever more fields; week level uses the weekday.
  always_comb begin
    case (ie_ff[2:0])
      3'h1: alarm_hit = nxt_ms == ms_alm_ff && sec_ff == sec_alm_ff[7:0];
      3'h2: alarm_hit = nxt_ms == ms_alm_ff && sec_ff == sec_alm_ff[7:0] &&
                        min_ff == min_alm_ff[7:0];
      3'h3: alarm_hit = nxt_ms == ms_alm_ff && sec_ff == sec_alm_ff[7:0] &&
                        min_ff == min_alm_ff[7:0] &&
                        hour_ff == hour_alm_ff[7:0];
      3'h4: alarm_hit = nxt_ms == ms_alm_ff && sec_ff == sec_alm_ff[7:0] &&
                        min_ff == min_alm_ff[7:0] &&
                        hour_ff == hour_alm_ff[7:0] &&
                        date_ff == day_alm_ff[7:0];
      3'h5: alarm_hit = nxt_ms == ms_alm_ff && sec_ff == sec_alm_ff[7:0] &&
                        min_ff == min_alm_ff[7:0] &&
                        hour_ff == hour_alm_ff[7:0] &&
                        wday_ff == day_alm_ff[10:8];
      default: alarm_hit = 1'b0;
    endcase
    alarm_hit = alarm_hit && step_ok && !c_sec;
    case (per_ff[2:0])
      3'h1:    per_hit = step_ok;
      3'h2:    per_hit = c_sec;
      3'h3:    per_hit = c_min;
      3'h4:    per_hit = c_hour;
      3'h5:    per_hit = c_day;
      default: per_hit = 1'b0;
    endcase
    per_hit = per_hit && ie_ff[`RTCW_IE_PER_BIT];
  end

  // Wake pin is sampled on crystal ticks, so a pulse of one period is seen.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      ws1_ff    <= 1'b0;
      ws2_ff    <= 1'b0;
      wake_t_ff <= 1'b0;
    end else begin
      ws1_ff <= i_wake_in;
      ws2_ff <= ws1_ff;
      if (tick) begin
        wake_t_ff <= ws2_ff;
      end
    end
  end

  assign wake_hit = tick && ws2_ff && !wake_t_ff && !o_wake_oe;

  // Event flags: hardware set wins over a write-one clear in the same tick.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      flags_ff <= 16'h0000;
    end else begin
      if (apply && pa_ff == `RTCW_OFS_FLAGS) begin
        flags_ff <= flags_ff & ~pd_ff;
      end
      if (alarm_hit) flags_ff[`RTCW_FL_ALARM_BIT]  <= 1'b1;
      if (per_hit)   flags_ff[`RTCW_FL_PERIOD_BIT] <= 1'b1;
      if (wake_hit)  flags_ff[`RTCW_FL_WAKE_BIT]   <= 1'b1;
    end
  end

  assign o_irq = |flags_ff[2:0];
  assign o_wake_oe  = ie_ff[`RTCW_IE_WAKE_OUT_BIT] &&
                      |flags_ff[1:0];
  assign o_wake_out = o_wake_oe;

  // Control and update clear while the core is off; all else keeps state.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      ie_ff  <= 16'h0000;
      upd_ff <= 16'h0000;
    end else if (iso_ff) begin
      ie_ff  <= 16'h0000;
      upd_ff <= 16'h0000;
    end else if (apply) begin
      if (pa_ff == `RTCW_OFS_INT_EN) ie_ff  <= pd_ff;
      if (pa_ff == `RTCW_OFS_UPDATE) upd_ff <= pd_ff;
    end
  end

  // Held registers: only the clock-supply reset clears them.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      ms_alm_ff   <= 12'h000;
      sec_alm_ff  <= 16'h0000;
      min_alm_ff  <= 16'h0000;
      hour_alm_ff <= 16'h0000;
      day_alm_ff  <= 16'h0000;
      mon_alm_ff  <= 16'h0000;
      year_alm_ff <= 16'h0000;
      per_ff      <= 16'h0000;
      drift_ff    <= 16'h0000;
      nopwr_ff    <= `RTCW_NOPWR_RST;
    end else if (apply) begin
      case (pa_ff)
        `RTCW_OFS_MS_ALM:    ms_alm_ff   <= pd_ff[11:0];
        `RTCW_OFS_SEC_ALM:   sec_alm_ff  <= pd_ff;
        `RTCW_OFS_MIN_ALM:   min_alm_ff  <= pd_ff;
        `RTCW_OFS_HOUR_ALM:  hour_alm_ff <= pd_ff;
        `RTCW_OFS_DAY_ALM:   day_alm_ff  <= pd_ff;
        `RTCW_OFS_MONTH_ALM: mon_alm_ff  <= pd_ff;
        `RTCW_OFS_YEAR_ALM:  year_alm_ff <= pd_ff;
        `RTCW_OFS_PER_SEL:   per_ff      <= pd_ff;
        `RTCW_OFS_DRIFT:     drift_ff    <= pd_ff;
        `RTCW_OFS_NOPWR:     nopwr_ff    <= nopwr_ff & ~pd_ff;
        default: ;
      endcase
    end
  end

  // Scratch words survive everything except loss of the clock supply.
  for (genvar g = 0; g < 4; g++) begin : g_scr
    localparam logic [15:0] OFS = (g == 0) ? `RTCW_OFS_SCR0 :
                                  (g == 1) ? `RTCW_OFS_SCR1 :
                                  (g == 2) ? `RTCW_OFS_SCR2 : `RTCW_OFS_SCR3;
    always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
        scr_ff[g] <= 16'h0000;
      end else if (apply && pa_ff == OFS) begin
        scr_ff[g] <= pd_ff;
      end
    end
  end

  // Oscillator and power control; a wake event restores the regulator.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      osc_ff <= `RTCW_OSC_RST;
      pwr_ff <= 16'h0000;
    end else begin
      if (osc_wr) begin
        osc_ff <= i_reg_wdata;
      end
      if (wake_hit || (o_wake_oe && ws2_ff)) begin
        pwr_ff[`RTCW_PM_CORE_REG_BIT] <= 1'b0;
        pwr_ff[`RTCW_PM_BANDGAP_BIT]  <= 1'b0;
      end else if (apply && pa_ff == `RTCW_OFS_PWR) begin
        pwr_ff <= pd_ff;
      end
    end
  end

  assign o_core_reg_off = pwr_ff[`RTCW_PM_CORE_REG_BIT] ||
                          pwr_ff[`RTCW_PM_BANDGAP_BIT];

  // Read port: isolated or unmapped reads return zero.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      rdata_ff <= 16'h0000;
    end else if (i_reg_rd) begin
      if (iso_ff) begin
        rdata_ff <= 16'h0000;
      end else begin
        case (i_reg_addr)
          `RTCW_OFS_INT_EN:    rdata_ff <= ie_ff;
          `RTCW_OFS_UPDATE:    rdata_ff <= upd_ff;
          `RTCW_OFS_MS:        rdata_ff <= {4'h0, ms_ff};
          `RTCW_OFS_MS_ALM:    rdata_ff <= {4'h0, ms_alm_ff};
          `RTCW_OFS_SEC:       rdata_ff <= {8'h00, sec_ff};
          `RTCW_OFS_SEC_ALM:   rdata_ff <= sec_alm_ff;
          `RTCW_OFS_MIN:       rdata_ff <= {8'h00, min_ff};
          `RTCW_OFS_MIN_ALM:   rdata_ff <= min_alm_ff;
          `RTCW_OFS_HOUR:      rdata_ff <= {8'h00, hour_ff};
          `RTCW_OFS_HOUR_ALM:  rdata_ff <= hour_alm_ff;
          `RTCW_OFS_DAY:       rdata_ff <= {5'h00, wday_ff, date_ff};
          `RTCW_OFS_DAY_ALM:   rdata_ff <= day_alm_ff;
          `RTCW_OFS_MONTH:     rdata_ff <= {8'h00, mon_ff};
          `RTCW_OFS_MONTH_ALM: rdata_ff <= mon_alm_ff;
          `RTCW_OFS_YEAR:      rdata_ff <= {8'h00, year_ff};
          `RTCW_OFS_YEAR_ALM:  rdata_ff <= year_alm_ff;
          `RTCW_OFS_FLAGS:     rdata_ff <= flags_ff;
          `RTCW_OFS_NOPWR:     rdata_ff <= nopwr_ff;
          `RTCW_OFS_PER_SEL:   rdata_ff <= per_ff;
          `RTCW_OFS_DRIFT:     rdata_ff <= drift_ff;
          `RTCW_OFS_OSC:       rdata_ff <= osc_ff;
          `RTCW_OFS_PWR:       rdata_ff <= pwr_ff;
          `RTCW_OFS_SCR0:      rdata_ff <= scr_ff[0];
          `RTCW_OFS_SCR1:      rdata_ff <= scr_ff[1];
          `RTCW_OFS_SCR2:      rdata_ff <= scr_ff[2];
          `RTCW_OFS_SCR3:      rdata_ff <= scr_ff[3];
          default:             rdata_ff <= 16'h0000;
        endcase
      end
    end
  end

  assign o_reg_rdata = rdata_ff;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);

  write_sync_a: assert property (
    wr_acc |=> st_ff == rtcw_pkg::rtcw_st_tick1 && !apply)
    else $error("write applied early");
  apply_late_a: assert property (
    apply |-> $past(st_ff) != rtcw_pkg::rtcw_st_idle &&
              st_ff == rtcw_pkg::rtcw_st_tick2)
    else $error("apply outside second tick");
  osc_block_a: assert property (
    (i_reg_wr && !osc_ff[`RTCW_OSC_EN_BIT]) |-> !wr_acc)
    else $error("write taken with oscillator off");
  ctrl_clear_a: assert property (
    iso_ff |=> ie_ff == 16'h0000 && upd_ff == 16'h0000)
    else $error("control kept while isolated");
  iso_read_a: assert property (
    (i_reg_rd && iso_ff) |=> o_reg_rdata == 16'h0000)
    else $error("read leaked through isolation");
  bcd_hour_a: assert property (
    hour_ff <= 8'h23 && sec_ff[3:0] <= 4'h9 && min_ff[3:0] <= 4'h9)
    else $error("time field out of range");
  leap_feb_a: assert property (
    (mon_ff == 8'h02 && date_ff == 8'h29 && $changed(date_ff)) |->
    is_leap(year_ff))
    else $error("february 29 in common year");
  alarm_flag_a: assert property (
    alarm_hit |=> flags_ff[`RTCW_FL_ALARM_BIT] && o_irq)
    else $error("alarm not flagged");
  period_flag_a: assert property (
    per_hit |=> flags_ff[`RTCW_FL_PERIOD_BIT] ##0 o_irq)
    else $error("periodic event lost");
  wake_pwr_a: assert property (
    wake_hit |=> !o_core_reg_off)
    else $error("wake did not restore regulator");

  cover_apply_c: cover property (apply && pend_time);
  cover_alarm_c: cover property (alarm_hit);
  cover_wake_c: cover property (wake_hit ##1 o_irq);
  cover_year_c: cover property (c_mon && mon_ff == 8'h12);

endmodule : rtcw_core

// ===== shared/rtcw_consts.svh
// Register offsets, field positions, reset values and timing constants.
`ifndef RTCW_CONSTS_SVH
`define RTCW_CONSTS_SVH
`define RTCW_OFS_INT_EN      16'h1900
`define RTCW_OFS_UPDATE      16'h1901
`define RTCW_OFS_MS          16'h1904
`define RTCW_OFS_MS_ALM      16'h1905
`define RTCW_OFS_SEC         16'h1908
`define RTCW_OFS_SEC_ALM     16'h1909
`define RTCW_OFS_MIN         16'h190C
`define RTCW_OFS_MIN_ALM     16'h190D
`define RTCW_OFS_HOUR        16'h1910
`define RTCW_OFS_HOUR_ALM    16'h1911
`define RTCW_OFS_DAY         16'h1914
`define RTCW_OFS_DAY_ALM     16'h1915
`define RTCW_OFS_MONTH       16'h1918
`define RTCW_OFS_MONTH_ALM   16'h1919
`define RTCW_OFS_YEAR        16'h191C
`define RTCW_OFS_YEAR_ALM    16'h191D
`define RTCW_OFS_FLAGS       16'h1920
`define RTCW_OFS_NOPWR       16'h1921
`define RTCW_OFS_PER_SEL     16'h1924
`define RTCW_OFS_DRIFT       16'h1928
`define RTCW_OFS_OSC         16'h192C
`define RTCW_OFS_PWR         16'h1930
`define RTCW_OFS_SCR0        16'h1960
`define RTCW_OFS_SCR1        16'h1961
`define RTCW_OFS_SCR2        16'h1964
`define RTCW_OFS_SCR3        16'h1965
`define RTCW_IE_PER_BIT      3
`define RTCW_IE_WAKE_OUT_BIT 4
`define RTCW_FL_ALARM_BIT    0
`define RTCW_FL_PERIOD_BIT   1
`define RTCW_FL_WAKE_BIT     2
`define RTCW_PM_CORE_REG_BIT 0
`define RTCW_PM_BANDGAP_BIT  1
`define RTCW_OSC_EN_BIT      0
`define RTCW_UPD_FREEZE_BIT  0
`define RTCW_OSC_RST         16'h0001
`define RTCW_NOPWR_RST       16'h0001
`define RTCW_BCD_ONE         8'h01
`define RTCW_MS_ACC_STEP     17'h003E8
`define RTCW_MS_ACC_BASE     17'h08000
`endif

// ===== shared/rtcw_pkg.sv
// Types shared by the always-on calendar block.
package rtcw_pkg;
  typedef enum logic [2:0] {
    rtcw_st_idle  = 3'b001,
    rtcw_st_tick1 = 3'b010,
    rtcw_st_tick2 = 3'b100
  } rtcw_sync_t;
endpackage : rtcw_pkg

// ===== verif/rtcw_ext_model.sv
// Crystal source and wake-pin driver outside the calendar block.
`timescale 1ns/1ns
module rtcw_ext_model (
  // Clock and wake request
  input  wire logic i_sys_clk,
  input  wire logic i_wake_req,
  // Crystal level and wake drive
  output logic      o_xtal_clk,
  output logic      o_wake_drv
);
  logic [2:0] div_ff = 3'h0;
  logic [5:0] wake_ff = 6'h00;
  // Crystal at one eighth of the bus rate keeps well above the 3x margin.
  always_ff @(posedge i_sys_clk) div_ff <= div_ff + 3'h1;
  assign o_xtal_clk = div_ff[2];
  // Wake is held four crystal periods, so no tick can miss it.
  always_ff @(posedge i_sys_clk) begin
    if (i_wake_req) wake_ff <= 6'h20;
    else if (wake_ff != 6'h00) wake_ff <= wake_ff - 6'h01;
  end
  assign o_wake_drv = (wake_ff != 6'h00);
endmodule : rtcw_ext_model

// ===== verif/rtcw_core_bench.sv
// Register-level bench for the always-on calendar block.
`timescale 1ns/1ns
`include "rtcw_consts.svh"
module rtcw_core_bench;
  logic        clk, rst, pg, wr, rd, wreq;
  logic [15:0] addr, wd, q;
  wire logic   xt, wdrv, w_out, w_oe, irq, roff, iso, srst, rdy;
  wire logic [15:0] rdat;
  // The pin is pulled low when nobody drives it.
  wire logic   wline = w_oe ? w_out : wdrv;
  int          err_count = 0;
  int          compares = 0;

  rtcw_core i_rtcw_core (.i_sys_clk(clk), .i_sys_rst(rst), .i_xtal_clk(xt),
    .i_core_pgood(pg), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_wdata(wd), .o_reg_rdata(rdat), .o_reg_ready(rdy),
    .i_wake_in(wline), .o_wake_out(w_out), .o_wake_oe(w_oe), .o_irq(irq),
    .o_core_reg_off(roff), .o_isolate(iso), .o_sys_reset(srst));
  rtcw_ext_model i_rtcw_ext_model (.i_sys_clk(clk), .i_wake_req(wreq),
    .o_xtal_clk(xt), .o_wake_drv(wdrv));

  task automatic chk(input logic [15:0] g, e);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic wait_rdy;
    int n;
    n = 0;
    while (rdy !== 1'b1 && n < 400) begin
      @(posedge clk);
      #1 n++;
    end
    chk({15'h0, rdy}, 16'h0001);
  endtask : wait_rdy
  task automatic wr_reg(input logic [15:0] a, d);
    wait_rdy();
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1 wait_rdy();
  endtask : wr_reg
  task automatic rd_reg(input logic [15:0] a, output logic [15:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdat;
  endtask : rd_reg
  task automatic rd_chk(input logic [15:0] a, e);
    rd_reg(a, q);
    chk(q, e);
  endtask : rd_chk
  // Seeds a date at 23:59:59 and waits for the midnight carry.
  task automatic roll(input logic [15:0] y, m, d);
    wr_reg(`RTCW_OFS_YEAR, y);
    wr_reg(`RTCW_OFS_MONTH, m);
    wr_reg(`RTCW_OFS_DAY, d);
    wr_reg(`RTCW_OFS_HOUR, 16'h0023);
    wr_reg(`RTCW_OFS_MIN, 16'h0059);
    wr_reg(`RTCW_OFS_SEC, 16'h0059);
    q = 16'h0059;
    for (int i = 0; i < 200 && q !== 16'h0000; i++) begin
      repeat (50) @(posedge clk);
      rd_reg(`RTCW_OFS_SEC, q);
    end
    chk(q, 16'h0000);
    rd_chk(`RTCW_OFS_HOUR, 16'h0000);
  endtask : roll
  task automatic tally_and_finish;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    tally_and_finish();
  end
  initial begin
    rst = 1'b1; pg = 1'b1; wr = 1'b0; rd = 1'b0; wreq = 1'b0;
    addr = 16'h0000; wd = 16'h0000;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_chk(`RTCW_OFS_OSC, `RTCW_OSC_RST);
    rd_chk(`RTCW_OFS_NOPWR, `RTCW_NOPWR_RST);
    rd_chk(`RTCW_OFS_DAY, 16'h0101);
    rd_chk(16'h1902, 16'h0000);
    // A read right behind a write must still see the old value.
    @(posedge clk);
    addr <= `RTCW_OFS_SCR0;
    wd <= 16'hA5C3;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdat, 16'h0000);
    chk({15'h0, rdy}, 16'h0000);
    wait_rdy();
    rd_chk(`RTCW_OFS_SCR0, 16'hA5C3);
    wr_reg(`RTCW_OFS_OSC, 16'h0000);
    wr_reg(`RTCW_OFS_SCR1, 16'h1234);
    rd_chk(`RTCW_OFS_SCR1, 16'h0000);
    wr_reg(`RTCW_OFS_OSC, `RTCW_OSC_RST);
    // A large negative drift makes every tick a millisecond step.
    wr_reg(`RTCW_OFS_DRIFT, 16'h83E8);
    roll(16'h0000, 16'h0002, 16'h0128);
    rd_chk(`RTCW_OFS_DAY, 16'h0229);
    roll(16'h0099, 16'h0012, 16'h0131);
    rd_chk(`RTCW_OFS_YEAR, 16'h0000);
    rd_chk(`RTCW_OFS_MONTH, 16'h0001);
    rd_chk(`RTCW_OFS_DAY, 16'h0201);
    wr_reg(`RTCW_OFS_PER_SEL, 16'h0001);
    wr_reg(`RTCW_OFS_INT_EN, 16'h0018);
    for (int i = 0; i < 200 && irq !== 1'b1; i++) @(posedge clk);
    #1 chk({15'h0, irq}, 16'h0001);
    chk({15'h0, w_oe}, 16'h0001);
    chk({15'h0, w_out}, 16'h0001);
    // A driven wake pin restores the regulator, so stop driving it first.
    wr_reg(`RTCW_OFS_INT_EN, 16'h0008);
    wr_reg(`RTCW_OFS_SCR2, 16'h5A5A);
    wr_reg(`RTCW_OFS_PWR, 16'h0001);
    chk({15'h0, roff}, 16'h0001);
    @(posedge clk);
    pg <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk({15'h0, iso}, 16'h0001);
    chk({15'h0, w_oe}, 16'h0000);
    rd_chk(`RTCW_OFS_SCR2, 16'h0000);
    @(posedge clk);
    wreq <= 1'b1;
    @(posedge clk);
    wreq <= 1'b0;
    for (int i = 0; i < 200 && roff !== 1'b0; i++) @(posedge clk);
    #1 chk({15'h0, roff}, 16'h0000);
    @(posedge clk);
    pg <= 1'b1;
    #1 chk({15'h0, srst}, 16'h0001);
    @(posedge clk);
    #1 chk({15'h0, iso}, 16'h0000);
    wait_rdy();
    rd_chk(`RTCW_OFS_SCR2, 16'h5A5A);
    rd_chk(`RTCW_OFS_INT_EN, 16'h0000);
    rd_chk(`RTCW_OFS_FLAGS, 16'h0006);
    wr_reg(`RTCW_OFS_FLAGS, 16'h0007);
    chk({15'h0, irq}, 16'h0000);
    // Alarm at second 30, millisecond 50; every tick is a millisecond.
    wr_reg(`RTCW_OFS_SEC_ALM, 16'h0030);
    wr_reg(`RTCW_OFS_MS_ALM, 16'h0050);
    wr_reg(`RTCW_OFS_SEC, 16'h0030);
    wr_reg(`RTCW_OFS_MS, 16'h0000);
    wr_reg(`RTCW_OFS_INT_EN, 16'h0001);
    for (int i = 0; i < 1000 && irq !== 1'b1; i++) @(posedge clk);
    #1 chk({15'h0, irq}, 16'h0001);
    rd_chk(`RTCW_OFS_FLAGS, 16'h0001);
    tally_and_finish();
  end
endmodule : rtcw_core_bench
